// ### src/dcs_sequencer.v
/*
 * DRAM cycle sequencer: write, 8/16/32-byte reads, partial write, refresh.
 * Assumes the request source holds req_valid and its fields until req_ready.
 */
`default_nettype none
`include "dcs_defs.vh"

module dcs_sequencer (
	input wire mclk,
	input wire rst_n,
	input wire req_valid,
	input wire req_write,
	input wire [2:0] req_len,
	input wire [1:0] req_addr,
	output wire req_ready,
	output reg ras_n,
	output reg cas_n,
	output reg we_n,
	output reg ecc_mode_upper,
	output reg ecc_mode_lower,
	output reg ecc_output_latch_strobe,
	output reg data_drive,
	output reg [3:0] byte_sel,
	output reg merge_active,
	output reg [2:0] cycle_kind,
	output reg busy
);
	localparam [5:0] K_IDLE = 6'h01;
	localparam [5:0] K_WR = 6'h02;
	localparam [5:0] K_RD = 6'h04;
	localparam [5:0] K_PW = 6'h08;
	localparam [5:0] K_REF = 6'h10;
	localparam [5:0] K_NONE = 6'h20;

	reg [5:0] kind;
	reg [`DCS_ST_W-1:0] st;
	reg [2:0] len;
	wire ref_req;
	wire ref_clear = (kind == K_REF) && (st == `DCS_S3);

	dcs_refresh_timer u_timer (
		.mclk(mclk),
		.rst_n(rst_n),
		.req_clear(ref_clear),
		.ref_req(ref_req)
	);

	function is_partial;
		input [2:0] l;
		begin
			is_partial = (l == `DCS_LEN_1) || (l == `DCS_LEN_2) || (l == `DCS_LEN_3);
		end
	endfunction

	function [3:0] last_state;
		input [5:0] k;
		input [2:0] l;
		begin
			case (k)
				K_WR: last_state = `DCS_LAST_WR;
				K_PW: last_state = `DCS_LAST_PW;
				K_REF: last_state = `DCS_LAST_REF;
				K_RD: last_state = (l == `DCS_LEN_32) ? `DCS_LAST_RD32 :
					(l == `DCS_LEN_16) ? `DCS_LAST_RD16 : `DCS_LAST_RD8;
				default: last_state = `DCS_S0;
			endcase
		end
	endfunction

	// Byte selects from low address and size
	function [3:0] sel_bytes;
		input [1:0] a;
		input [2:0] l;
		reg [3:0] m;
		begin
			m = (l == `DCS_LEN_1) ? 4'h1 : (l == `DCS_LEN_2) ? 4'h3 : 4'h7;
			sel_bytes = m << a;
		end
	endfunction

	// Reads end in a state that overlaps the next S0
	wire rd_overlap = (kind == K_RD);
	wire at_last = (kind != K_IDLE) && (st == last_state(kind, len));
	wire can_start = (kind == K_IDLE) || at_last;
	wire rd_req = req_valid && !req_write;
	wire [5:0] req_kind = !req_write ? K_RD :
		(is_partial(req_len) ? K_PW : K_WR);
	wire len_ok = req_write || (req_len == `DCS_LEN_8) ||
		(req_len == `DCS_LEN_16) || (req_len == `DCS_LEN_32);
	wire take_ref = can_start && ref_req && (kind != K_REF);
	// Ready withheld while refresh is pending
	assign req_ready = can_start && !ref_req && req_valid && len_ok;

	reg [5:0] next_kind;
	reg [`DCS_ST_W-1:0] next_st;
	always @* begin
		next_kind = kind;
		next_st = st + 4'h1;
		if (can_start) begin
			if (take_ref) begin
				next_kind = K_REF;
				next_st = (rd_overlap && at_last) ? `DCS_S1 : `DCS_S0;
			end else if (req_ready) begin
				next_kind = req_kind;
				// Read's final state doubles as the new S0
				next_st = (rd_overlap && at_last) ? `DCS_S1 : `DCS_S0;
			end else begin
				next_kind = K_IDLE;
				next_st = `DCS_S0;
			end
		end
		if (!rd_req && rd_overlap && at_last && !req_ready && !take_ref) begin
			next_kind = K_IDLE;
			next_st = `DCS_S0;
		end
	end

	// Strobe and mode decode for a given state
	reg n_ras, n_cas, n_we, n_up, n_lo, n_led, n_drv, n_mrg;
	always @* begin
		n_ras = 1'b0;
		n_cas = 1'b0;
		n_we = 1'b0;
		n_up = 1'b0;
		n_lo = 1'b0;
		n_led = 1'b0;
		n_drv = 1'b0;
		n_mrg = 1'b0;
		case (next_kind)
			K_WR: begin
				n_ras = (next_st >= `DCS_S1) && (next_st < `DCS_S4);
				n_cas = (next_st >= `DCS_S2) && (next_st < `DCS_S4);
				n_we = (next_st == `DCS_S3);
				n_drv = (next_st >= `DCS_S1) && (next_st < `DCS_S4);
			end
			K_RD: begin
				n_ras = (next_st >= `DCS_S1) && (next_st < ((len == `DCS_LEN_8) ?
					`DCS_S4 : (len == `DCS_LEN_16) ? `DCS_S7 : `DCS_S13));
				n_cas = (next_st >= `DCS_S2) && n_ras && (next_st != `DCS_S4) &&
					(next_st != `DCS_S7) && (next_st != `DCS_S10);
				n_up = (next_st >= `DCS_S2);
				n_lo = (next_st >= `DCS_S4) && (next_st != `DCS_S6) &&
					(next_st != `DCS_S8 || len == `DCS_LEN_16) &&
					(next_st != `DCS_S9) && (next_st != `DCS_S12);
				n_cas = n_cas || ((len == `DCS_LEN_32) && (next_st == `DCS_S11));
				n_lo = n_lo && !((len == `DCS_LEN_32) && (next_st == `DCS_S11));
			end
			K_PW: begin
				n_ras = (next_st >= `DCS_S1) && (next_st < `DCS_S8);
				n_cas = (next_st >= `DCS_S2) && (next_st < `DCS_S8);
				n_up = (next_st >= `DCS_S2) && (next_st < `DCS_S6);
				n_lo = (next_st >= `DCS_S4) && (next_st < `DCS_S6);
				// Latch strobe rises in S6 and drops with the enables in S8
				n_led = (next_st >= `DCS_S6) && (next_st < `DCS_S8);
				n_mrg = (next_st >= `DCS_S6) && (next_st < `DCS_S8);
				n_drv = n_mrg;
				n_we = (next_st == `DCS_S7);
			end
			K_REF: begin
				n_cas = (next_st >= `DCS_S1) && (next_st < `DCS_S3);
				n_ras = (next_st >= `DCS_S2) && (next_st < `DCS_S5);
			end
			default: begin
				n_ras = 1'b0;
			end
		endcase
	end

	always @(posedge mclk) begin
		if (!rst_n) begin
			kind <= K_IDLE;
			st <= `DCS_S0;
			len <= 3'h0;
			ras_n <= 1'b1;
			cas_n <= 1'b1;
			we_n <= 1'b1;
			ecc_mode_upper <= 1'b0;
			ecc_mode_lower <= 1'b0;
			ecc_output_latch_strobe <= 1'b0;
			data_drive <= 1'b0;
			merge_active <= 1'b0;
			byte_sel <= 4'h0;
			cycle_kind <= 3'h0;
			busy <= 1'b0;
		end else begin
			kind <= next_kind;
			st <= next_st;
			if (req_ready && !take_ref) begin
				len <= req_len;
				byte_sel <= is_partial(req_len) ? sel_bytes(req_addr, req_len) : 4'hF;
			end
			ras_n <= !n_ras;
			cas_n <= !n_cas;
			we_n <= !n_we;
			ecc_mode_upper <= n_up;
			ecc_mode_lower <= n_lo;
			ecc_output_latch_strobe <= n_led;
			data_drive <= n_drv;
			merge_active <= n_mrg;
			cycle_kind <= {next_kind == K_REF, next_kind == K_PW, next_kind == K_RD};
			busy <= (next_kind != K_IDLE);
		end
	end
endmodule
`default_nettype wire

// ### src/dcs_defs.vh
/*
 * Constants for the DRAM cycle sequencer: size codes, state numbers, timing.
 * Assumes a 50 MHz mclk; the cycle state advances once per mclk period.
 */
`ifndef DCS_DEFS_VH
`define DCS_DEFS_VH

`define DCS_LEN_W 3
`define DCS_ST_W 4
`define DCS_LEN_1 3'h1
`define DCS_LEN_2 3'h2
`define DCS_LEN_3 3'h3
`define DCS_LEN_8 3'h5
`define DCS_LEN_16 3'h6
`define DCS_LEN_32 3'h7

`define DCS_S0 4'h0
`define DCS_S1 4'h1
`define DCS_S2 4'h2
`define DCS_S3 4'h3
`define DCS_S4 4'h4
`define DCS_S5 4'h5
`define DCS_S6 4'h6
`define DCS_S7 4'h7
`define DCS_S8 4'h8
`define DCS_S9 4'h9
`define DCS_S10 4'hA
`define DCS_S11 4'hB
`define DCS_S12 4'hC
`define DCS_S13 4'hD
`define DCS_S14 4'hE

`define DCS_LAST_WR 4'h4
`define DCS_LAST_RD8 4'h5
`define DCS_LAST_RD16 4'h8
`define DCS_LAST_RD32 4'hE
`define DCS_LAST_PW 4'h8
`define DCS_LAST_REF 4'h6

`define DCS_CLK_MHZ 50
`define DCS_REF_COUNT_SYS 312
`define DCS_SYS_MHZ 20
`define DCS_REF_W 10

`endif

// ### src/dcs_refresh_timer.v
/*
 * Refresh interval timer: raises a sticky refresh request each interval.
 * Assumes the sequencer clears the request from its refresh cycle.
 */
`default_nettype none
`include "dcs_defs.vh"

module dcs_refresh_timer (
	input wire mclk,
	input wire rst_n,
	input wire req_clear,
	output reg ref_req
);
	// Interval is 312 system clocks at 20 MHz, rescaled to mclk
	localparam [`DCS_REF_W-1:0] REF_CYC =
		(`DCS_REF_COUNT_SYS * `DCS_CLK_MHZ) / `DCS_SYS_MHZ;
	reg [`DCS_REF_W-1:0] cnt;
	wire carry = (cnt == REF_CYC - 10'h001);

	always @(posedge mclk) begin
		if (!rst_n) begin
			cnt <= 10'h000;
			ref_req <= 1'b0;
		end else begin
			cnt <= carry ? 10'h000 : cnt + 10'h001;
			if (carry)
				ref_req <= 1'b1;
			else if (req_clear)
				ref_req <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### testbench/dcs_seq_asserts.sv
/* Strobe and mode timing checks for dcs_sequencer.
 Bound to every dcs_sequencer instance. */
`default_nettype none
module dcs_seq_asserts (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [2:0] req_len,
	input wire logic req_ready,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic ecc_mode_upper,
	input wire logic ecc_mode_lower,
	input wire logic ecc_output_latch_strobe,
	input wire logic data_drive,
	input wire logic merge_active
);
	timeunit 1ns;
	timeprecision 1ns;
	wire tk = req_valid && req_ready;
	wire rd = tk && !req_write;
	wire pw = tk && req_write && req_len >= 3'h1 && req_len <= 3'h3;
	wire fw = tk && req_write && !pw;
	wire off = ras_n && cas_n;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence s_open;
		!ras_n ##1 !cas_n;
	endsequence
	property p_wr;
		fw |-> ##2 s_open ##1 !we_n ##1 (off && we_n);
	endproperty
	a_wr: assert property (p_wr) else $error("write strobes");
	property p_wr_data;
		fw |-> ##2 (data_drive && !ecc_mode_upper && !ecc_mode_lower) [*3];
	endproperty
	a_wr_data: assert property (p_wr_data) else $error("write data");
	property p_rd8;
		rd && req_len == 3'h5 |-> ##2 s_open ##2 off;
	endproperty
	a_rd8: assert property (p_rd8) else $error("read strobes");
	property p_modes;
		rd |-> ##2 !ecc_mode_upper ##1 (ecc_mode_upper && !ecc_mode_lower) ##2 ecc_mode_lower;
	endproperty
	a_modes: assert property (p_modes) else $error("read modes");
	property p_rd8_end;
		rd && req_len == 3'h5 |-> ##6 ecc_mode_lower ##1 !(ecc_mode_upper || ecc_mode_lower);
	endproperty
	a_rd8_end: assert property (p_rd8_end) else $error("read end");
	property p_rd16;
		rd && req_len == 3'h6 |-> ##5 (cas_n && !ras_n) ##1 !cas_n ##2 off;
	endproperty
	a_rd16: assert property (p_rd16) else $error("16 byte");
	property p_rd32;
		rd && req_len == 3'h7 |-> ##6 !cas_n ##3 !cas_n ##3 !cas_n ##2 off;
	endproperty
	a_rd32: assert property (p_rd32) else $error("32 byte");
	property p_pw;
		pw |-> ##2 s_open ##5 (!we_n && ecc_output_latch_strobe) ##1 (off && we_n);
	endproperty
	a_pw: assert property (p_pw) else $error("partial write");
	property p_merge;
		pw |-> ##7 (merge_active && data_drive && ecc_output_latch_strobe) ##1
			(merge_active && !we_n) ##1
			!(merge_active || data_drive || ecc_output_latch_strobe);
	endproperty
	a_merge: assert property (p_merge) else $error("merge phase");
	property p_ref;
		$fell(cas_n) && ras_n |-> ##1 !ras_n ##1 cas_n ##2 ras_n;
	endproperty
	a_ref: assert property (p_ref) else $error("refresh");
endmodule
bind dcs_sequencer dcs_seq_asserts chk_u (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid),
	.req_write(req_write), .req_len(req_len), .req_ready(req_ready), .ras_n(ras_n),
	.cas_n(cas_n), .we_n(we_n), .ecc_mode_upper(ecc_mode_upper),
	.ecc_mode_lower(ecc_mode_lower), .ecc_output_latch_strobe(ecc_output_latch_strobe),
	.data_drive(data_drive), .merge_active(merge_active));
`default_nettype wire

// ### testbench/dcs_dram_model.sv
/* DRAM bank model: counts CAS accesses per row open and CBR refreshes.
 Watches registered strobes on mclk. */
`default_nettype none
module dcs_dram_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ras_n,
	input wire logic cas_n,
	output logic [2:0] cas_cnt,
	output logic [7:0] ref_cnt
);
	timeunit 1ns;
	timeprecision 1ns;
	logic ras_q;
	logic cas_q;
	always @(posedge mclk) begin
		ras_q <= ras_n;
		cas_q <= cas_n;
		if (!rst_n) begin
			cas_cnt <= 3'h0;
			ref_cnt <= 8'h00;
		end else if (cas_q && !cas_n && ras_n) begin
			ref_cnt <= ref_cnt + 8'h01;
		end else if (ras_q && !ras_n && cas_n) begin
			cas_cnt <= 3'h0;
		end else if (cas_q && !cas_n) begin
			cas_cnt <= cas_cnt + 3'h1;
		end
	end
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
/* Self-checking bench for dcs_sequencer with a DRAM model.
 Assumes the checker is bound by its own file. */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, rst_n = 0, req_valid = 0, req_write = 0;
	logic [2:0] req_len = 3'h0;
	logic [1:0] req_addr = 2'h0;
	wire req_ready, ras_n, cas_n, we_n, ecc_mode_upper, ecc_mode_lower, els, data_drive, mact, busy;
	wire [3:0] byte_sel;
	wire [2:0] cycle_kind, cas_cnt;
	wire [7:0] ref_cnt;
	int fail_count = 0, checks = 0, i, n;
	logic [11:0] r;
	logic [2:0] kind;
	logic [3:0] bs;
	// Row: write, size, addr, kind, CAS count
	logic [11:0] rows [8] = '{12'h801, 12'hCC1, 12'h9D1, 12'hA91, 12'hB51, 12'h509, 12'h60A, 12'h78C};
	always #10 mclk = ~mclk;
	dcs_sequencer dut_u (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
		.req_len(req_len), .req_addr(req_addr), .req_ready(req_ready), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .ecc_mode_upper(ecc_mode_upper),
		.ecc_mode_lower(ecc_mode_lower), .ecc_output_latch_strobe(els),
		.data_drive(data_drive), .byte_sel(byte_sel), .merge_active(mact),
		.cycle_kind(cycle_kind), .busy(busy));
	dcs_dram_model mem_u (.mclk(mclk), .rst_n(rst_n), .ras_n(ras_n), .cas_n(cas_n),
		.cas_cnt(cas_cnt), .ref_cnt(ref_cnt));
	task cmp(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task final_report;
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task issue(input logic [11:0] q);
		req_valid <= 1'b1;
		req_write <= q[11];
		req_len <= q[10:8];
		req_addr <= q[7:6];
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (req_ready !== 1'b1 && n < 2000);
		if (n >= 2000)
			fail_count++;
		req_valid <= 1'b0;
	endtask
	initial begin
		#200000;
		fail_count++;
		final_report;
	end
	initial begin
		repeat (16) @(posedge mclk);
		#1 cmp(16'({ras_n, cas_n, we_n, busy, data_drive}), 16'h001C);
		@(posedge mclk);
		rst_n <= 1'b1;
		for (i = 0; i < 8; i++) begin
			r = rows[i];
			issue(r);
			repeat (2) @(posedge mclk);
			#1 kind = cycle_kind;
			bs = byte_sel;
			n = 0;
			do begin
				@(posedge mclk);
				n++;
			end while (busy !== 1'b0 && n < 50);
			cmp(16'(kind), 16'(r[5:3]));
			cmp(16'(cas_cnt), 16'(r[2:0]));
			if (r[11] && r[4])
				cmp(16'(bs), 16'((4'h1 << r[10:8]) - 4'h1) << r[7:6]);
			else if (r[11])
				cmp(16'(bs), 16'h000F);
		end
		req_valid <= 1'b1;
		req_write <= 1'b0;
		req_len <= 3'h0;
		n = 0;
		repeat (30) begin
			@(posedge mclk);
			if (req_ready === 1'b1)
				n++;
		end
		req_valid <= 1'b0;
		cmp(16'(n), 16'h0000);
		for (int k = 0; k < 2; k++) begin
			i = ref_cnt;
			n = 0;
			while (ref_cnt == i && n < 2000) begin
				@(posedge mclk);
				n++;
			end
		end
		cmp(16'(n), 16'd780);
		issue(rows[7]);
		repeat (4) @(posedge mclk);
		rst_n <= 1'b0;
		@(posedge mclk);
		#1 cmp(16'({ras_n, cas_n, we_n}), 16'h0007);
		final_report;
	end
endmodule
`default_nettype wire
